/* verilog/sipc_pkg.sv */
// types and constants shared by the strand pick and issue control
package sipc_pkg;

  // ****************************************
  // core shape
  // ****************************************
  localparam int STRANDS = 8;
  localparam int GROUP_SIZE = 4;
  localparam int GROUPS = 2;
  localparam int GROUP_IDX_W = 2;

  // ****************************************
  // latencies in core cycles
  // ****************************************
  localparam logic [4:0] LAT_VAR = 5'h00; // completion reported by the unit
  localparam logic [4:0] LAT_ONE = 5'h01;
  localparam logic [4:0] LAT_LOAD = 5'h03;
  localparam logic [4:0] LAT_SIX = 5'h06;
  localparam logic [4:0] LAT_CAS = 5'h14; // 20 at least, 30 at most
  localparam logic [4:0] LAT_WIN = 5'h19; // 25
  localparam logic [4:0] LAT_TAKEN = 5'h06;

  // cycles a strand is held back after its issue cycle; HOLD_TAKEN counts from the taken branch resolve instead
  localparam logic [4:0] HOLD_NONE = 5'h00;
  localparam logic [4:0] HOLD_SIX = LAT_SIX - 5'h01;
  localparam logic [4:0] HOLD_WIN = LAT_WIN - 5'h01;
  localparam logic [4:0] HOLD_TAKEN = LAT_TAKEN - 5'h01;

  // ****************************************
  // instruction classes seen by the picker
  // ****************************************
  typedef enum logic [3:0] {
    OP_ALU,      // add, add_with_carry_op, and, and_not_op
    OP_MISALIGN, // misalign_addr_calc_op, misalign_addr_calc_le_op
    OP_BRANCH,   // int_cond_branch_pred_op, reg_cond_branch_op, fp branches
    OP_WIN,      // windows_clean_op, byte_mask_write_op, window_flush_op
    OP_CAS,      // word_compare_swap_op, dword_compare_swap_op
    OP_FP6,      // float_graphics_unit six cycle ops
    OP_ADDR6,    // blocked address conversion, edge processing
    OP_CTI6,     // call and link, trap return
    OP_LOAD,
    OP_STORE,
    OP_SERIAL,   // state reads and writes, mul, div, barriers and the like
    OP_FP_STATE  // fp_state_load_op, fp_state_store_ext_op
  } sipc_op_t;

  typedef struct packed {
    logic valid;
    sipc_op_t op;
    logic [31:0] instr;
  } sipc_fetch_t;

  typedef struct packed {
    logic valid;
    logic [2:0] strand;
    logic taken;
  } sipc_resolve_t;

  typedef struct packed {
    logic valid;
    logic [2:0] strand;
    sipc_op_t op;
    logic [4:0] lat;
    logic [31:0] instr;
  } sipc_issue_t;

  localparam sipc_issue_t ISSUE_RST = '0;

endpackage : sipc_pkg

/* verilog/sipc_lrp_pick.sv */
// least recently picked selector for one thread group
`timescale 1ns/1ps
`default_nettype none

module sipc_lrp_pick #(
  parameter int N = 4,
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [N-1:0] req,
  input wire logic take,
  output logic [N-1:0] gnt,
  output logic [W-1:0] idx,
  output logic any
);

  // ord[0] is the strand picked longest ago
  logic [N-1:0][W-1:0] ord;
  logic [N-1:0][W-1:0] next_ord;
  logic [W-1:0] pos;

  // scan from the tail so the oldest requester wins
  always_comb begin
    idx = '0;
    pos = '0;
    any = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (req[ord[k]]) begin
        idx = ord[k];
        pos = W'(k);
        any = 1'b1;
      end
    end
    gnt = any ? (N'(1) << idx) : '0;
  end

  // winner moves to the tail, the rest close up
  always_comb begin
    next_ord = ord;
    for (int k = 0; k < N - 1; k++) begin
      if (W'(k) >= pos) begin
        next_ord[k] = ord[k + 1];
      end
    end
    next_ord[N-1] = idx;
  end

  // order only moves when the pick really issued
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int k = 0; k < N; k++) begin
        ord[k] <= W'(k);
      end
    end else if (take && any) begin
      ord <= next_ord; // see RULE2
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_lrp_rotate;
    (take && any && $countones(req) > 1) ##1 (req == $past(req)) |-> gnt != $past(gnt);
  endproperty
  a_lrp_rotate: assert property (p_lrp_rotate) else $error("same strand picked twice over an older one"); // see RULE2

endmodule : sipc_lrp_pick

`default_nettype wire

/* verilog/sipc_avail_timer.sv */
// per strand availability hold: fixed count or wait for release
`timescale 1ns/1ps
`default_nettype none

module sipc_avail_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic start_wait,
  input wire logic [4:0] start_cnt,
  input wire logic release_now,
  input wire logic penalty,
  output logic avail
);

  logic [4:0] cnt;
  logic waiting;

  // start only comes while available, so it never meets a pending release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= sipc_pkg::HOLD_NONE;
      waiting <= 1'b0;
    end else if (start) begin
      cnt <= start_cnt;
      waiting <= start_wait;
    end else begin
      if (penalty) begin
        cnt <= sipc_pkg::HOLD_TAKEN; // see RULE13
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
      if (release_now) begin
        waiting <= 1'b0;
      end
    end
  end

  assign avail = (cnt == 5'h00) && !waiting;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_win_hold;
    (start && !start_wait && start_cnt == sipc_pkg::HOLD_WIN) |-> ##24 !avail ##1 avail;
  endproperty
  a_win_hold: assert property (p_win_hold) else $error("window op hold is not 25 cycles"); // see RULE14

  property p_six_hold;
    (start && !start_wait && start_cnt == sipc_pkg::HOLD_SIX) |=> (!avail)[*5] ##1 avail;
  endproperty
  a_six_hold: assert property (p_six_hold) else $error("six cycle hold wrong"); // see RULE17

  property p_taken;
    (penalty && !start) |=> (!avail)[*5] ##1 (avail || waiting);
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch penalty wrong"); // see RULE13

endmodule : sipc_avail_timer

`default_nettype wire

/* verilog/sipc_core_ctl.sv */
// strand pick and issue control for one multithreaded core
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// RULE1 - eight strands in two groups, strands 0-3 and 4-7
// RULE2 - each group picks its least recently picked available strand every cycle
// RULE3 - at most two issues a cycle, at most one per group
// RULE4 - at most one memory op and one float/graphics op per cycle
// RULE5 - shared unit clash goes to the group that used it longest ago
// RULE6 - strands switch every cycle; stalls only on shared unit clashes
// RULE7 - speculation enable: branches not taken, loads assumed to hit
// RULE8 - serialising and long ops hold their strand until requirements are met
// RULE9 - speculation off: branches and loads also hold their strand
// RULE10 - latencies are single strand minimums; other strands fill the gaps
// RULE11 - add, add with carry, and, and-not take one cycle
// RULE12 - misaligned address calculation, both endians, takes one cycle
// RULE13 - conditional branches: one cycle not taken, six cycles taken
// RULE14 - window clean, byte mask write, window flush take 25 cycles
// RULE15 - compare and swap runs in second level cache, 20 to 30 cycles
// RULE16 - float add, mul, compare, move, negate, abs, graphics ops: six cycles
// RULE17 - address conversion, call, trap return, edge ops: six cycles
// RULE18 - a group losing arbitration keeps its instruction and retries next cycle
//

module sipc_core_ctl (
  input wire logic clk,
  input wire logic reset,
  input wire logic spec_enable,
  input wire sipc_pkg::sipc_fetch_t [7:0] fe_req,
  output logic [7:0] fe_take,
  input wire logic [7:0] exe_release,
  input wire sipc_pkg::sipc_resolve_t exe_resolve,
  output var sipc_pkg::sipc_issue_t [1:0] issue
);

  // ****************************************
  // instruction class decode
  // ****************************************

  // latency reported with each issue
  function automatic logic [4:0] op_lat(
    input sipc_pkg::sipc_op_t op
  );
    case (op)
      sipc_pkg::OP_ALU: op_lat = sipc_pkg::LAT_ONE; // see RULE11
      sipc_pkg::OP_MISALIGN: op_lat = sipc_pkg::LAT_ONE; // see RULE12
      sipc_pkg::OP_BRANCH: op_lat = sipc_pkg::LAT_ONE; // see RULE13
      sipc_pkg::OP_WIN: op_lat = sipc_pkg::LAT_WIN; // see RULE14
      sipc_pkg::OP_CAS: op_lat = sipc_pkg::LAT_CAS; // see RULE15
      sipc_pkg::OP_FP6: op_lat = sipc_pkg::LAT_SIX; // see RULE16
      sipc_pkg::OP_ADDR6: op_lat = sipc_pkg::LAT_SIX; // see RULE17
      sipc_pkg::OP_CTI6: op_lat = sipc_pkg::LAT_SIX; // see RULE17
      sipc_pkg::OP_LOAD: op_lat = sipc_pkg::LAT_LOAD;
      sipc_pkg::OP_STORE: op_lat = sipc_pkg::LAT_ONE;
      default: op_lat = sipc_pkg::LAT_VAR;
    endcase
  endfunction : op_lat

  // fixed cycles the strand sits out after issue
  function automatic logic [4:0] op_hold(
    input sipc_pkg::sipc_op_t op
  );
    case (op)
      sipc_pkg::OP_WIN: op_hold = sipc_pkg::HOLD_WIN; // see RULE14
      sipc_pkg::OP_CTI6: op_hold = sipc_pkg::HOLD_SIX; // see RULE17
      default: op_hold = sipc_pkg::HOLD_NONE;
    endcase
  endfunction : op_hold

  // ops that keep the strand out until the unit releases it
  function automatic logic op_waits(
    input sipc_pkg::sipc_op_t op,
    input logic spec
  );
    case (op)
      sipc_pkg::OP_CAS: op_waits = 1'b1; // see RULE15
      sipc_pkg::OP_SERIAL: op_waits = 1'b1; // see RULE8
      sipc_pkg::OP_FP_STATE: op_waits = 1'b1; // see RULE8
      sipc_pkg::OP_BRANCH: op_waits = !spec; // see RULE9
      sipc_pkg::OP_LOAD: op_waits = !spec; // see RULE7
      default: op_waits = 1'b0;
    endcase
  endfunction : op_waits

  // the single load/store unit
  function automatic logic op_lsu(
    input sipc_pkg::sipc_op_t op
  );
    case (op)
      sipc_pkg::OP_LOAD: op_lsu = 1'b1;
      sipc_pkg::OP_STORE: op_lsu = 1'b1;
      sipc_pkg::OP_CAS: op_lsu = 1'b1;
      sipc_pkg::OP_FP_STATE: op_lsu = 1'b1;
      default: op_lsu = 1'b0;
    endcase
  endfunction : op_lsu

  // the single float_graphics_unit
  function automatic logic op_fgu(
    input sipc_pkg::sipc_op_t op
  );
    op_fgu = (op == sipc_pkg::OP_FP6);
  endfunction : op_fgu

  // ****************************************
  // per strand request and availability
  // ****************************************

  logic [7:0] avail;
  logic [7:0] req_all;
  logic [7:0] res_hit;

  for (genvar s = 0; s < sipc_pkg::STRANDS; s++) begin : strand
    // a strand asks only while it holds an instruction and is free
    assign req_all[s] = fe_req[s].valid & avail[s];
    assign res_hit[s] = exe_resolve.valid & (exe_resolve.strand == 3'(s));

    // fixed holds overlap with other strands rather than stall the core
    sipc_avail_timer u_hold (
      .clk(clk),
      .reset(reset),
      .start(fe_take[s]),
      .start_wait(op_waits(fe_req[s].op, spec_enable)), // see RULE8
      .start_cnt(op_hold(fe_req[s].op)), // see RULE10
      .release_now(exe_release[s] | res_hit[s]),
      .penalty(res_hit[s] & exe_resolve.taken), // see RULE13
      .avail(avail[s])
    );
  end

  // ****************************************
  // thread group pick
  // ****************************************

  logic [1:0][3:0] g_req;
  logic [1:0][3:0] g_gnt;
  logic [1:0][1:0] g_idx;
  logic [1:0][2:0] g_sid;
  logic [1:0] g_any;
  logic [1:0] g_go;
  logic [1:0] g_lsu;
  logic [1:0] g_fgu;
  sipc_pkg::sipc_op_t [1:0] g_op;

  // shared unit arbitration state: group that used it longest ago
  logic lsu_lru;
  logic fgu_lru;
  logic next_lsu_lru;
  logic next_fgu_lru;
  logic lsu_clash;
  logic fgu_clash;

  for (genvar g = 0; g < sipc_pkg::GROUPS; g++) begin : grp
    // strands 4g..4g+3 belong to group g
    assign g_req[g] = req_all[g*4 +: 4]; // see RULE1
    assign g_sid[g] = {1'(g), g_idx[g]}; // see RULE1
    assign g_op[g] = fe_req[g_sid[g]].op;
    assign g_lsu[g] = g_any[g] & op_lsu(g_op[g]);
    assign g_fgu[g] = g_any[g] & op_fgu(g_op[g]);

    // the loser of a clash simply does not take; fetch keeps the word
    assign g_go[g] = g_any[g]
                   & ~(lsu_clash & (lsu_lru != 1'(g)))
                   & ~(fgu_clash & (fgu_lru != 1'(g))); // see RULE18

    sipc_lrp_pick #(
      .N(sipc_pkg::GROUP_SIZE),
      .W(sipc_pkg::GROUP_IDX_W)
    ) u_pick (
      .clk(clk),
      .reset(reset),
      .req(g_req[g]),
      .take(g_go[g]), // see RULE2
      .gnt(g_gnt[g]),
      .idx(g_idx[g]),
      .any(g_any[g])
    );
  end

  // ****************************************
  // shared unit arbitration
  // ****************************************

  // one pick per group, so a clash only needs both groups on one unit
  assign lsu_clash = &g_lsu; // see RULE4
  assign fgu_clash = &g_fgu; // see RULE4

  // whichever group used the unit, the other becomes first in line
  assign next_lsu_lru = (g_go[0] & g_lsu[0]) ? 1'b1
                      : (g_go[1] & g_lsu[1]) ? 1'b0
                      : lsu_lru; // see RULE5
  assign next_fgu_lru = (g_go[0] & g_fgu[0]) ? 1'b1
                      : (g_go[1] & g_fgu[1]) ? 1'b0
                      : fgu_lru; // see RULE5

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lsu_lru <= 1'b0;
      fgu_lru <= 1'b0;
    end else begin
      lsu_lru <= next_lsu_lru;
      fgu_lru <= next_fgu_lru;
    end
  end

  // ****************************************
  // fetch acknowledge
  // ****************************************

  // combinational take back to fetch; no extra stage, so no switch penalty
  for (genvar s = 0; s < sipc_pkg::STRANDS; s++) begin : take
    assign fe_take[s] = g_go[s / 4] & g_gnt[s / 4][s % 4]; // see RULE6
  end

  // ****************************************
  // issue register
  // ****************************************

  sipc_pkg::sipc_issue_t [1:0] next_issue;

  for (genvar g = 0; g < sipc_pkg::GROUPS; g++) begin : iss
    // up to one instruction per group reaches the units
    assign next_issue[g] = '{
      valid: g_go[g], // see RULE3
      strand: g_sid[g],
      op: g_op[g],
      lat: op_lat(g_op[g]),
      instr: fe_req[g_sid[g]].instr
    };
  end

  // payload follows the pick even when idle; valid qualifies it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      issue <= {sipc_pkg::ISSUE_RST, sipc_pkg::ISSUE_RST};
    end else begin
      issue <= next_issue;
    end
  end

  // ****************************************
  // checks
  // ****************************************

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_group_range;
    (issue[0].valid |-> !issue[0].strand[2]) and (issue[1].valid |-> issue[1].strand[2]);
  endproperty
  a_group_range: assert property (p_group_range) else $error("strand issued from wrong group"); // see RULE1

  property p_two_max;
    $onehot0(fe_take[3:0]) && $onehot0(fe_take[7:4]);
  endproperty
  a_two_max: assert property (p_two_max) else $error("more than one take in a group"); // see RULE3

  sequence s_both_issue;
    issue[0].valid && issue[1].valid;
  endsequence

  property p_one_lsu;
    s_both_issue |-> !(op_lsu(issue[0].op) && op_lsu(issue[1].op));
  endproperty
  a_one_lsu: assert property (p_one_lsu) else $error("two memory ops issued together"); // see RULE4

  property p_one_fgu;
    s_both_issue |-> !(op_fgu(issue[0].op) && op_fgu(issue[1].op));
  endproperty
  a_one_fgu: assert property (p_one_fgu) else $error("two float ops issued together"); // see RULE4

  sequence s_lsu_twice;
    lsu_clash ##1 lsu_clash;
  endsequence

  property p_lsu_fair;
    s_lsu_twice |-> g_go != $past(g_go);
  endproperty
  a_lsu_fair: assert property (p_lsu_fair) else $error("memory unit clash won twice by one group"); // see RULE5

  property p_no_stall;
    !(lsu_clash || fgu_clash) |=> issue[0].valid == $past(g_any[0]) && issue[1].valid == $past(g_any[1]);
  endproperty
  a_no_stall: assert property (p_no_stall) else $error("group stalled without a clash"); // see RULE6

  property p_spec_load;
    (issue[0].valid && issue[0].op == sipc_pkg::OP_LOAD && $past(spec_enable)) |-> avail[issue[0].strand];
  endproperty
  a_spec_load: assert property (p_spec_load) else $error("speculated load held its strand"); // see RULE7

  property p_serial_hold;
    (issue[0].valid && issue[0].op == sipc_pkg::OP_SERIAL) |-> !avail[issue[0].strand];
  endproperty
  a_serial_hold: assert property (p_serial_hold) else $error("serialising op left strand free"); // see RULE8

  property p_nospec_hold;
    (issue[1].valid && issue[1].op inside {sipc_pkg::OP_LOAD, sipc_pkg::OP_BRANCH} && !$past(spec_enable))
      |-> !avail[issue[1].strand];
  endproperty
  a_nospec_hold: assert property (p_nospec_hold) else $error("unspeculated op left strand free"); // see RULE9

  property p_one_cycle;
    (issue[0].valid && issue[0].op inside {sipc_pkg::OP_ALU, sipc_pkg::OP_MISALIGN}) |-> issue[0].lat == 5'h01;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("simple op latency not one"); // see RULE11 see RULE12

  property p_fp_six;
    (issue[1].valid && issue[1].op == sipc_pkg::OP_FP6) |-> issue[1].lat == sipc_pkg::LAT_SIX;
  endproperty
  a_fp_six: assert property (p_fp_six) else $error("float op latency not six"); // see RULE16

  property p_retry;
    lsu_clash |-> !fe_take[g_sid[~lsu_lru]] ##1 !issue[~$past(lsu_lru)].valid;
  endproperty
  a_retry: assert property (p_retry) else $error("clash loser took its instruction"); // see RULE18

endmodule : sipc_core_ctl

`default_nettype wire

/* verif/sipc_fe_model.sv */
// fetch front end model: one waiting instruction per strand
`timescale 1ns/1ps
`default_nettype none

module sipc_fe_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] push,
  input wire sipc_pkg::sipc_fetch_t [1:0] push_data,
  input wire logic [7:0] fe_take,
  output var sipc_pkg::sipc_fetch_t [7:0] fe_req
);
  // ****************************************
  // per strand slot
  // ****************************************
  // a slot holds its instruction until taken, so a refused strand retries unchanged;
  // an empty slot flips its data every cycle so a stale word never looks valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fe_req <= '0;
    end else begin
      for (int s = 0; s < 8; s++) begin
        if (push[s]) begin
          fe_req[s] <= push_data[s / 4];
          fe_req[s].instr <= push_data[s / 4].instr ^ 32'(s);
        end else if (fe_take[s] && fe_req[s].valid) begin
          fe_req[s].valid <= 1'b0;
        end else if (!fe_req[s].valid) begin
          fe_req[s].instr <= ~fe_req[s].instr;
        end
      end
    end
  end
endmodule : sipc_fe_model

`default_nettype wire

/* verif/tb_strand_pick_and_issue_control.sv */
// self-checking testbench for the strand pick and issue control
`timescale 1ns/1ps
`default_nettype none

module tb_strand_pick_and_issue_control;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic spec_enable = 1'b1;
  logic [7:0] push = 8'h00;
  sipc_pkg::sipc_fetch_t [1:0] push_data = '0;
  logic [7:0] exe_release = 8'h00;
  sipc_pkg::sipc_resolve_t exe_resolve = '0;
  sipc_pkg::sipc_fetch_t [7:0] fe_req;
  logic [7:0] fe_take;
  sipc_pkg::sipc_issue_t [1:0] issue;
  logic [31:0] base = 32'h0000_0000;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  // ****************************************
  // clock, cycle count, instances
  // ****************************************
  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  sipc_core_ctl sipc_core_ctl_inst (
    .clk(clk), .reset(reset), .spec_enable(spec_enable), .fe_req(fe_req),
    .fe_take(fe_take), .exe_release(exe_release), .exe_resolve(exe_resolve), .issue(issue)
  );

  sipc_fe_model sipc_fe_model_inst (
    .clk(clk), .reset(reset), .push(push), .push_data(push_data), .fe_take(fe_take), .fe_req(fe_req)
  );

  // ****************************************
  // compare and drive tasks
  // ****************************************
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp_bit

  // group 0 strands get op0, group 1 strands op1; each push gets a fresh word
  task automatic push_ops(input logic [7:0] m, input sipc_pkg::sipc_op_t op0, input sipc_pkg::sipc_op_t op1);
    @(posedge clk);
    base <= base + 32'h0000_0100;
    push <= m;
    push_data <= {{1'b1, op1, base + 32'h0000_0100}, {1'b1, op0, base + 32'h0000_0100}};
    @(posedge clk);
    push <= 8'h00;
  endtask : push_ops

  // takes are combinational, so they are looked at mid-cycle
  task automatic wait_take(input int s, input int max, output int at);
    at = -1;
    for (int i = 0; i < max && at < 0; i++) begin
      @(negedge clk);
      if (fe_take[s] === 1'b1) at = cyc;
    end
    cmp_bit(at >= 0, 1'b1);
  endtask : wait_take

  task automatic check_issue(input int s, input logic [4:0] lat);
    @(negedge clk);
    cmp_bit(issue[s / 4].valid, 1'b1);
    cmp_val(32'(issue[s / 4].strand), 32'(s));
    cmp_val(32'(issue[s / 4].lat), 32'(lat));
    cmp_val(issue[s / 4].instr, base ^ 32'(s));
  endtask : check_issue

  task automatic take_chk(input int s, input logic [4:0] lat, output int at);
    wait_take(s, 4, at);
    check_issue(s, lat);
  endtask : take_chk

  task automatic no_take(input int s, input int n);
    repeat (n) begin
      @(negedge clk);
      cmp_bit(fe_take[s], 1'b0);
    end
  endtask : no_take

  task automatic expect_takes(input logic [7:0] v1, input logic [7:0] v2);
    @(negedge clk);
    cmp_val(32'(fe_take), 32'(v1));
    @(negedge clk);
    cmp_val(32'(fe_take), 32'(v2));
  endtask : expect_takes

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_alu;
    int t;
    push_ops(8'h11, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    @(negedge clk);
    cmp_val(32'(fe_take), 32'h0000_0011);
    check_issue(0, sipc_pkg::LAT_ONE);
    cmp_bit(issue[1].valid, 1'b1);
    push_ops(8'h20, sipc_pkg::OP_MISALIGN, sipc_pkg::OP_MISALIGN);
    take_chk(5, sipc_pkg::LAT_ONE, t);
    $display("test alu done");
  endtask : t_alu

  task automatic t_lrp;
    int order [4] = '{1, 2, 3, 0};
    push_ops(8'h0F, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    foreach (order[k]) begin
      @(negedge clk);
      cmp_val(32'(fe_take), 32'h1 << order[k]);
    end
    $display("test pick order done");
  endtask : t_lrp

  task automatic t_clash;
    int t;
    push_ops(8'h11, sipc_pkg::OP_LOAD, sipc_pkg::OP_STORE);
    expect_takes(8'h01, 8'h10);
    check_issue(4, sipc_pkg::LAT_ONE);
    push_ops(8'h01, sipc_pkg::OP_FP6, sipc_pkg::OP_FP6);
    take_chk(0, sipc_pkg::LAT_SIX, t);
    push_ops(8'h11, sipc_pkg::OP_FP6, sipc_pkg::OP_FP6);
    expect_takes(8'h10, 8'h01);
    push_ops(8'h22, sipc_pkg::OP_LOAD, sipc_pkg::OP_FP6);
    expect_takes(8'h22, 8'h00);
    $display("test shared unit done");
  endtask : t_clash

  task automatic t_hold;
    int t0;
    int t1;
    push_ops(8'h04, sipc_pkg::OP_WIN, sipc_pkg::OP_WIN);
    take_chk(2, sipc_pkg::LAT_WIN, t0);
    push_ops(8'h06, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    wait_take(1, 2, t1);
    wait_take(2, 30, t1);
    cmp_val(32'(t1 - t0), 32'd25);
    push_ops(8'h40, sipc_pkg::OP_CTI6, sipc_pkg::OP_CTI6);
    take_chk(6, sipc_pkg::LAT_SIX, t0);
    push_ops(8'h40, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    wait_take(6, 10, t1);
    cmp_val(32'(t1 - t0), 32'd6);
    $display("test fixed hold done");
  endtask : t_hold

  // op waits until execution says its needs are met
  task automatic wait_release(input int s, input sipc_pkg::sipc_op_t op, input logic [4:0] lat);
    int t;
    push_ops(8'h01 << s, op, op);
    take_chk(s, lat, t);
    push_ops(8'h01 << s, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    no_take(s, 6);
    @(posedge clk);
    exe_release <= 8'h01 << s;
    @(posedge clk);
    exe_release <= 8'h00;
    wait_take(s, 1, t);
  endtask : wait_release

  task automatic t_wait;
    wait_release(3, sipc_pkg::OP_CAS, sipc_pkg::LAT_CAS);
    wait_release(3, sipc_pkg::OP_SERIAL, sipc_pkg::LAT_VAR);
    $display("test wait release done");
  endtask : t_wait

  task automatic t_spec;
    int t;
    push_ops(8'h80, sipc_pkg::OP_LOAD, sipc_pkg::OP_LOAD);
    take_chk(7, sipc_pkg::LAT_LOAD, t);
    push_ops(8'h80, sipc_pkg::OP_BRANCH, sipc_pkg::OP_BRANCH);
    wait_take(7, 1, t);
    check_issue(7, sipc_pkg::LAT_ONE);
    push_ops(8'h80, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    wait_take(7, 1, t);
    @(posedge clk);
    spec_enable <= 1'b0;
    wait_release(7, sipc_pkg::OP_LOAD, sipc_pkg::LAT_LOAD);
    push_ops(8'h80, sipc_pkg::OP_BRANCH, sipc_pkg::OP_BRANCH);
    take_chk(7, sipc_pkg::LAT_ONE, t);
    push_ops(8'h80, sipc_pkg::OP_ALU, sipc_pkg::OP_ALU);
    no_take(7, 4);
    @(posedge clk);
    exe_resolve <= {1'b1, 3'h7, 1'b1};
    @(posedge clk);
    exe_resolve <= '0;
    no_take(7, 5);
    wait_take(7, 1, t);
    $display("test speculation done");
  endtask : t_spec

  // ****************************************
  // verdict, watchdog, main sequence
  // ****************************************
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_alu();
    t_lrp();
    t_clash();
    t_hold();
    t_wait();
    t_spec();
    results();
  end
endmodule : tb_strand_pick_and_issue_control

`default_nettype wire
